// >>> hdl/queue_defs.svh
/*
  Constants for the shared command byte queue: register offsets, field
  positions, reset values and sizes.
  Assumes inclusion by bare name from design files.
*/
`ifndef QUEUE_DEFS_SVH
`define QUEUE_DEFS_SVH

`define Q_DEPTH 64
`define Q_PTR_W 6
`define Q_CNT_W 7
`define Q_THR_W 6
`define Q_THR_RESET 6'h08

`define ADDR_W 12
`define OFS_DATA 12'h000
`define OFS_COUNT 12'h004
`define OFS_STATUS 12'h008
`define OFS_CONTROL 12'h00C
`define OFS_THRESH 12'h010
`define OFS_INT_EN 12'h014
`define OFS_INT_FLAG 12'h018

`define BIT_LOW 0
`define BIT_HIGH 1
`define BIT_OVERRUN 4
`define BIT_IRQ 3
`define BIT_CLEAR 0
`define BIT_SET_FLAGS 7

`endif

// >>> hdl/queue_pkg.sv
/*
  Types for the shared command byte queue.
  Assumes the constants header is compiled alongside.
*/
package queue_pkg;
  typedef enum logic [1:0] {
    ACC_NONE = 2'b00,
    ACC_HOST = 2'b01,
    ACC_ENGINE = 2'b10
  } access_owner_type;
endpackage

// >>> hdl/shared_command_byte_fifo.sv
/*
  Shared 64x8 byte queue between an APB host and an internal command
  engine, with fill count, overrun flag, clear, threshold warnings and
  a level interrupt output.
  Assumes the engine runs on mclk and issues one-cycle push/pop strobes.
*/
// Chosen here: the register offsets and the APB slave port.
// What this block does
// - One queue of 64 byte entries
// - Host write stores byte, advances write pointer
// - Host read returns byte, advances read pointer
// - Fill count equals pointer distance, readable
// - Engine and host share the one queue
// - Clear resets pointers, count and overrun
// - Write while full sets sticky overrun
// - Only clear removes the overrun flag
// - High warning when free space within threshold
// - Low warning when count within threshold
// - Low warning rise raises enabled interrupt
// - Warning rise sets its interrupt flag
// - Threshold resets to eight
`timescale 1ns/1ns
`include "queue_defs.svh"

module shared_command_byte_fifo #(
  parameter int DEPTH = `Q_DEPTH
) (
  input wire logic mclk, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [`ADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic eng_push, // Engine push strobe
  input wire logic [7:0] eng_push_data, // Engine push byte
  input wire logic eng_pop, // Engine pop strobe
  output logic [7:0] eng_pop_data, // Engine popped byte
  output logic eng_pop_valid, // Engine popped byte valid
  output logic eng_busy, // Engine request held off last cycle, now pending
  output logic irq // Interrupt output
);

  // ==========================================================
  // Storage and pointers
  logic [7:0] mem [DEPTH];
  logic [`Q_PTR_W-1:0] wptr_reg;
  logic [`Q_PTR_W-1:0] rptr_reg;
  logic [`Q_CNT_W-1:0] count_reg;
  logic overrun_reg;
  logic [`Q_THR_W-1:0] thresh_reg;
  logic [1:0] int_en_reg;
  logic [1:0] int_flag_reg;
  logic high_prev_reg;
  logic low_prev_reg;
  logic eng_pend_reg;
  logic eng_pend_push_reg;
  logic [7:0] eng_pend_data_reg;

  // ==========================================================
  // Bus decode
  logic acc;
  logic wr;
  logic rd;
  logic host_push;
  logic host_pop;
  logic clear;
  logic int_en_wr;
  logic int_flag_wr;
  logic thresh_wr;
  logic known;
  assign acc = psel && penable && pready;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign host_push = wr && (paddr == `OFS_DATA);
  assign host_pop = rd && (paddr == `OFS_DATA);
  assign clear = wr && (paddr == `OFS_CONTROL) && pwdata[`BIT_CLEAR];
  assign int_en_wr = wr && (paddr == `OFS_INT_EN);
  assign int_flag_wr = wr && (paddr == `OFS_INT_FLAG);
  assign thresh_wr = wr && (paddr == `OFS_THRESH);
  assign known = (paddr == `OFS_DATA) || (paddr == `OFS_COUNT) ||
    (paddr == `OFS_STATUS) || (paddr == `OFS_CONTROL) ||
    (paddr == `OFS_THRESH) || (paddr == `OFS_INT_EN) ||
    (paddr == `OFS_INT_FLAG);

  // ==========================================================
  // Arbitration: host wins, engine request waits one cycle; a clear drops it
  logic eng_req;
  logic eng_req_push;
  logic [7:0] eng_req_data;
  logic host_q;
  queue_pkg::access_owner_type owner;
  assign host_q = host_push || host_pop;
  assign eng_req = eng_pend_reg || eng_push || eng_pop;
  assign eng_req_push = eng_pend_reg ? eng_pend_push_reg : eng_push;
  assign eng_req_data = eng_pend_reg ? eng_pend_data_reg : eng_push_data;
  always_comb begin
    if (clear) begin
      owner = queue_pkg::ACC_NONE;
    end else if (host_q) begin
      owner = queue_pkg::ACC_HOST;
    end else if (eng_req) begin
      owner = queue_pkg::ACC_ENGINE;
    end else begin
      owner = queue_pkg::ACC_NONE;
    end
  end

  logic do_push;
  logic do_pop;
  logic [7:0] push_byte;
  logic full;
  logic empty;
  assign full = (count_reg == `Q_CNT_W'(DEPTH));
  assign empty = (count_reg == '0);
  always_comb begin
    do_push = 1'b0;
    do_pop = 1'b0;
    push_byte = pwdata[7:0];
    case (owner)
      queue_pkg::ACC_HOST: begin
        do_push = host_push;
        do_pop = host_pop;
      end
      queue_pkg::ACC_ENGINE: begin
        do_push = eng_req_push;
        do_pop = !eng_req_push;
        push_byte = eng_req_data;
      end
      default: begin
        do_push = 1'b0;
      end
    endcase
  end
  logic push_ok;
  logic pop_ok;
  assign push_ok = do_push && !full;
  assign pop_ok = do_pop && !empty;

  // Hold an engine request that lost arbitration to a host data access
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      eng_pend_reg <= 1'b0;
      eng_pend_push_reg <= 1'b0;
      eng_pend_data_reg <= 8'h00;
    end else if (owner == queue_pkg::ACC_HOST && eng_req) begin
      eng_pend_reg <= 1'b1;
      eng_pend_push_reg <= eng_req_push;
      eng_pend_data_reg <= eng_req_data;
    end else begin
      eng_pend_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Queue state
  always_ff @(posedge mclk) begin
    if (push_ok) begin
      mem[wptr_reg] <= push_byte;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count_reg <= '0;
    end else if (clear) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push_ok) begin
        wptr_reg <= wptr_reg + `Q_PTR_W'(1);
      end
      if (pop_ok) begin
        rptr_reg <= rptr_reg + `Q_PTR_W'(1);
      end
      if (push_ok && !pop_ok) begin
        count_reg <= count_reg + `Q_CNT_W'(1);
      end else if (pop_ok && !push_ok) begin
        count_reg <= count_reg - `Q_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      overrun_reg <= 1'b0;
    end else if (do_push && full) begin
      overrun_reg <= 1'b1;
    end else if (clear) begin
      overrun_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Threshold warnings and interrupt
  logic high_warn;
  logic low_warn;
  assign high_warn =
    (`Q_CNT_W'(DEPTH) - count_reg) <= {1'b0, thresh_reg};
  assign low_warn = count_reg <= {1'b0, thresh_reg};

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      thresh_reg <= `Q_THR_RESET;
    end else if (thresh_wr) begin
      thresh_reg <= pwdata[`Q_THR_W-1:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      high_prev_reg <= 1'b0;
      low_prev_reg <= 1'b0;
    end else begin
      high_prev_reg <= high_warn;
      low_prev_reg <= low_warn;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      int_en_reg <= 2'b00;
    end else if (int_en_wr) begin
      if (pwdata[`BIT_SET_FLAGS]) begin
        int_en_reg <= int_en_reg | pwdata[1:0];
      end else begin
        int_en_reg <= int_en_reg & ~pwdata[1:0];
      end
    end
  end

  logic [1:0] rise;
  logic [1:0] flag_next;
  assign rise = {high_warn && !high_prev_reg, low_warn && !low_prev_reg};
  always_comb begin
    flag_next = int_flag_reg;
    if (int_flag_wr) begin
      if (pwdata[`BIT_SET_FLAGS]) begin
        flag_next = flag_next | pwdata[1:0];
      end else begin
        flag_next = flag_next & ~pwdata[1:0];
      end
    end
    flag_next = flag_next | rise;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      int_flag_reg <= 2'b00;
      irq <= 1'b0;
    end else begin
      int_flag_reg <= flag_next;
      irq <= |(flag_next & int_en_reg);
    end
  end

  // ==========================================================
  // APB answer and engine pop data
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !known;
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        if (paddr == `OFS_DATA) begin
          prdata <= {24'h00_0000, mem[rptr_reg]};
        end else if (paddr == `OFS_COUNT) begin
          prdata <= {25'h000_0000, count_reg};
        end else if (paddr == `OFS_STATUS) begin
          prdata <= {27'h000_0000, overrun_reg, irq, 1'b0,
            high_warn, low_warn};
        end else if (paddr == `OFS_THRESH) begin
          prdata <= {26'h000_0000, thresh_reg};
        end else if (paddr == `OFS_INT_EN) begin
          prdata <= {30'h0000_0000, int_en_reg};
        end else if (paddr == `OFS_INT_FLAG) begin
          prdata <= {30'h0000_0000, int_flag_reg};
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      eng_pop_data <= 8'h00;
      eng_pop_valid <= 1'b0;
      eng_busy <= 1'b0;
    end else begin
      eng_pop_valid <= owner == queue_pkg::ACC_ENGINE && pop_ok;
      eng_pop_data <= mem[rptr_reg];
      eng_busy <= owner == queue_pkg::ACC_HOST && eng_req;
    end
  end

  // ==========================================================
  // Checks
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  chk_count_bound: assert property (count_reg <= `Q_CNT_W'(DEPTH))
    else $error("count above depth");
  chk_clear_zero: assert property (
    clear |=> count_reg == '0 && wptr_reg == rptr_reg && !overrun_reg)
    else $error("clear did not empty queue");
  chk_overrun_set: assert property (
    do_push && full && !clear |=> overrun_reg) else $error("overrun not set");
  chk_overrun_sticky: assert property (
    overrun_reg && !clear |=> overrun_reg) else $error("overrun dropped");
  chk_full_discard: assert property (
    full && !pop_ok && !clear |=> $stable(wptr_reg) && full)
    else $error("full write changed state");
  chk_push_count: assert property (
    push_ok && !pop_ok && !clear |=> count_reg == $past(count_reg) + 1'b1)
    else $error("push count wrong");
  chk_pop_ptr: assert property (
    pop_ok && !clear |=> rptr_reg == $past(rptr_reg) + 1'b1)
    else $error("pop pointer wrong");
  chk_low_irq: assert property (
    rise[0] && int_en_reg[0] && !int_en_wr |=> irq && int_flag_reg[0])
    else $error("low interrupt missing");
  chk_high_irq: assert property (
    rise[1] && int_en_reg[1] && !int_en_wr |=> irq && int_flag_reg[1])
    else $error("high interrupt missing");
  chk_engine_kept: assert property (
    host_q && eng_req && !clear |=> eng_pend_reg)
    else $error("engine request lost");

endmodule

// >>> verif/engine_model.sv
/*
  Behavioural model of the internal command engine at the far side.
  Assumes the bench raises go_push or go_pop for one mclk cycle.
*/
`timescale 1ns/1ns
module engine_model (
  input wire logic mclk, // Clock
  input wire logic rst_n, // Reset, active low
  input wire logic go_push, // Bench asks for a push
  input wire logic go_pop, // Bench asks for a pop
  input wire logic [7:0] go_data, // Byte to push
  input wire logic eng_busy, // Request deferred
  output logic eng_push, // Push strobe
  output logic [7:0] eng_push_data, // Push byte
  output logic eng_pop // Pop strobe
);
  // ==========================================
  // Strobes, held back while a deferral is pending
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      eng_push <= 1'b0;
      eng_pop <= 1'b0;
      eng_push_data <= 8'h00;
    end else begin
      eng_push <= go_push & !eng_busy;
      eng_pop <= go_pop & !eng_busy;
      // Idle data toggles so a stale byte is never seen
      eng_push_data <= go_push ? go_data : ~eng_push_data;
    end
  end
endmodule

// >>> verif/shared_command_byte_fifo_tb.sv
/*
  Self-checking bench: APB host tasks, engine model, result queues.
  Assumes the design answers each APB access in its own time.
*/
`timescale 1ns/1ns
`include "queue_defs.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module shared_command_byte_fifo_tb;
  logic mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, s = 77;
  logic pready, pslverr, eng_push, eng_pop, eng_pop_valid, eng_busy, irq;
  logic go_push = 0, go_pop = 0;
  logic [7:0] go_data = 0, eng_push_data, eng_pop_data;
  logic [7:0] mq[$], eq[$], ev;
  logic [33:0] xq[$], e;
  int errors = 0, n_checks = 0;
  always #5 mclk = ~mclk;
  shared_command_byte_fifo shared_command_byte_fifo_inst (.mclk(mclk),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .eng_push(eng_push), .eng_push_data(eng_push_data),
    .eng_pop(eng_pop), .eng_pop_data(eng_pop_data),
    .eng_pop_valid(eng_pop_valid), .eng_busy(eng_busy), .irq(irq));
  engine_model engine_model_inst (.mclk(mclk), .rst_n(rst_n),
    .go_push(go_push), .go_pop(go_pop), .go_data(go_data),
    .eng_busy(eng_busy), .eng_push(eng_push),
    .eng_push_data(eng_push_data), .eng_pop(eng_pop));
  // ==========================================
  // Helpers
  function automatic logic [31:0] xs();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic final_report();
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [32:0] x);
    int k;
    @(posedge mclk);
    xq.push_back({w, x});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (!pready && k < 20);
    if (!pready) begin
      errors++;
      final_report();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0_0000_0000);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, {1'b0, x});
  endtask
  task automatic eng(input logic p, input logic q, input logic [7:0] d);
    @(posedge mclk);
    go_push <= p;
    go_pop <= q;
    go_data <= d;
    @(posedge mclk);
    go_push <= 1'b0;
    go_pop <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask
  // ==========================================
  // Result watchers
  always @(posedge mclk) begin
    if (psel && penable && pready) begin
      e = xq.pop_front();
      if (e[33]) `CHK(pslverr, e[32])
      else `CHK({pslverr, prdata}, e[32:0])
    end
    if (eng_pop_valid) begin
      ev = eq.pop_front();
      `CHK(eng_pop_data, ev)
    end
  end
  // ==========================================
  // Scenarios
  initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    rd(`OFS_THRESH, 32'h0000_0008);
    rd(`OFS_COUNT, 32'h0000_0000);
    rd(`OFS_INT_FLAG, 32'h0000_0001);
    wr(`OFS_INT_FLAG, 32'h0000_0003);
    wr(`OFS_INT_EN, 32'h0000_0082);
    for (int i = 0; i < 64; i++) begin
      mq.push_back(8'(xs()));
      wr(`OFS_DATA, {24'h0, mq[i]});
      if (i == 54) rd(`OFS_STATUS, 32'h0000_0000);
      if (i == 55) rd(`OFS_STATUS, 32'h0000_000A);
    end
    rd(`OFS_COUNT, 32'h0000_0040);
    wr(`OFS_DATA, 32'h0000_00EE);
    rd(`OFS_STATUS, 32'h0000_001A);
    rd(`OFS_COUNT, 32'h0000_0040);
    wr(`OFS_INT_EN, 32'h0000_0002);
    wr(`OFS_INT_EN, 32'h0000_0081);
    wr(`OFS_INT_FLAG, 32'h0000_0001);
    #1 `CHK(irq, 1'b0)
    for (int i = 0; i < 64; i++)
      rd(`OFS_DATA, {24'h0, mq.pop_front()});
    rd(`OFS_STATUS, 32'h0000_0019);
    rd(`OFS_INT_FLAG, 32'h0000_0003);
    #1 `CHK(irq, 1'b1)
    wr(`OFS_CONTROL, 32'h0000_0001);
    rd(`OFS_STATUS, 32'h0000_0009);
    rd(`OFS_CONTROL, 32'h0000_0000);
    apb(1'b0, 12'hFFC, 32'h0, 33'h1_0000_0000);
    eq.push_back(8'h5C);
    wr(`OFS_DATA, 32'h0000_005C);
    eng(1'b0, 1'b1, 8'h00);
    eng(1'b1, 1'b0, 8'hA3);
    rd(`OFS_DATA, 32'h0000_00A3);
    fork
      wr(`OFS_DATA, 32'h0000_0011);
      eng(1'b1, 1'b0, 8'h22);
      begin
        repeat (3) @(posedge mclk);
        #1 `CHK(eng_busy, 1'b1)
      end
    join
    rd(`OFS_COUNT, 32'h0000_0002);
    rd(`OFS_DATA, 32'h0000_0011);
    rd(`OFS_DATA, 32'h0000_0022);
    `CHK(eq.size(), 0)
    repeat (3) @(posedge mclk);
    final_report();
  end
endmodule
